// >>> core/fpu_exc_params.svh
// constants of the floating-point exception control block
`ifndef FPU_EXC_PARAMS_SVH
`define FPU_EXC_PARAMS_SVH

// register byte offsets and decoded address width
`define ADDR_W 8
`define CSR_ADDR 8'h00
`define STAT_ADDR 8'h04

// exception bit positions inside a cause vector
`define EXC_I 0
`define EXC_U 1
`define EXC_O 2
`define EXC_Z 3
`define EXC_V 4
`define EXC_E 5
`define IEEE_N 5
`define CAUSE_N 6

// control/status word field positions
`define CSR_RM_LSB 0
`define CSR_FLAG_LSB 2
`define CSR_EN_LSB 7
`define CSR_CAUSE_LSB 12
`define CSR_FS_BIT 24
`define STAT_IRQ_BIT 0

// reset values
`define RM_RESET 2'h0
`define EN_RESET 5'h00
`define FLAG_RESET 5'h00
`define CAUSE_RESET 6'h00

// number formats
`define SP_EXP_W 8
`define SP_MAN_W 23
`define DP_EXP_W 11
`define DP_MAN_W 52

`endif

// >>> core/fpu_exc_pkg.sv
// types shared by the floating-point exception control block
package fpu_exc_pkg;
    typedef enum logic [1:0] {
        round_to_nearest = 2'h0,
        round_toward_zero = 2'h1,
        round_toward_plus = 2'h2,
        round_toward_minus = 2'h3
    } rmode_type;

    typedef enum logic [2:0] {
        val_zero = 3'h0,
        val_inf = 3'h1,
        val_max = 3'h2,
        val_min = 3'h3,
        val_qnan = 3'h4
    } special_type;
endpackage

// >>> core/fpu_exception_control.sv
// exception classification, flags, trap request and default results
//
// Behaviour
// - each IEEE exception's enable bit alone picks trap or flag-only
// - a trap still sets the cause bits but makes no destination write at all
// - without a trap the substitute value is written to the destination
// - unimplemented has no enable or flag; always traps, interrupt only when fp interrupt enabled
// - every raised exception sets its own cause bit
// - enable clear: flag bit set, no interrupt
// - enable set: flag untouched, interrupt request raised only when fp interrupt enabled
// - with a trap the cpu sees the float exception code; cause extends it
// - a flag goes to 1 on an untrapped exception and holds until written
// - untrapped inexact delivers the rounded result in every mode
// - untrapped underflow, nearest or toward zero: signed zero
// - underflow toward plus/minus: smallest same-signed normal or zero
// - untrapped overflow, nearest: infinity with intermediate sign
// - untrapped overflow, toward zero: largest finite, intermediate sign
// - overflow toward plus/minus: infinity on that side, else largest
// - untrapped divide by zero delivers correctly signed infinity
// - untrapped invalid operation delivers a quiet not-a-number
// - conversion out of integer range raises unimplemented, not invalid
// - normalized exponent below minimum raises unimplemented, or underflow and inexact when ftz_ok
// - normalized exponent above maximum raises overflow and inexact
// - denormalized or quiet nan operand raises unimplemented
`timescale 1ns/1ns
`include "fpu_exc_params.svh"

module fpu_exception_control
    import fpu_exc_pkg::*;
#(
    parameter logic [4:0] FLOAT_EXCEPTION_CODE = 5'h01 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic i_fp_int_en,
    input wire logic i_op_valid,
    input wire logic i_op_double,
    input wire logic [4:0] i_dest_idx,
    input wire logic [63:0] i_rounded_result,
    input wire logic i_result_sign,
    input wire logic i_inexact,
    input wire logic i_invalid,
    input wire logic i_div_zero,
    input wire logic i_exp_overflow,
    input wire logic i_exp_underflow,
    input wire logic i_conv_overflow,
    input wire logic i_denorm_qnan_src,
    input wire logic i_unimpl_op,
    output logic o_dest_we,
    output logic [4:0] o_dest_idx,
    output logic [63:0] o_dest_data,
    output logic o_fp_irq,
    output logic [4:0] o_exc_code
);

    localparam int SE = `SP_EXP_W;
    localparam int SM = `SP_MAN_W;
    localparam int DE = `DP_EXP_W;
    localparam int DM = `DP_MAN_W;

    // ====================================================================
    // bus slave
    // ====================================================================
    logic wr_pend_q;
    logic [`ADDR_W-1:0] addr_q;
    logic wr_csr;
    logic sel_rd;
    logic [31:0] csr_word;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    // every access finishes with zero wait states; hsize is not decoded
    // because only whole-word transfers are supported
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend_q <= 1'b0;
            addr_q <= '0;
        end else if (i_hready) begin
            wr_pend_q <= i_hsel & i_htrans[1] & i_hwrite;
            addr_q <= i_haddr[`ADDR_W-1:0];
        end
    end

    assign wr_csr = wr_pend_q && (addr_q == `CSR_ADDR);
    assign sel_rd = i_hready & i_hsel & i_htrans[1] & ~i_hwrite;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // ====================================================================
    // control/status state
    // ====================================================================
    logic [1:0] rm_q;
    logic fs_q;
    logic [`IEEE_N-1:0] en_q;
    logic [`IEEE_N-1:0] flag_q;
    logic [`CAUSE_N-1:0] cause_q;
    logic [`IEEE_N-1:0] en_d;
    logic [`IEEE_N-1:0] flag_d;
    logic [`CAUSE_N-1:0] cause_d;
    logic [`CAUSE_N-1:0] cause_n;
    logic ftz_ok;
    logic trap_req;
    logic irq_d;

    // underflow may only be finished in hardware when flush is on and
    // neither underflow nor inexact traps; otherwise software takes over
    assign ftz_ok = fs_q & ~en_q[`EXC_U] & ~en_q[`EXC_I];

    always_comb begin
        cause_n = '0;
        cause_n[`EXC_E] = i_unimpl_op
            | i_conv_overflow
            | (i_exp_underflow & ~ftz_ok)
            | i_denorm_qnan_src;
        cause_n[`EXC_V] = i_invalid & ~i_conv_overflow;
        cause_n[`EXC_Z] = i_div_zero;
        cause_n[`EXC_O] = i_exp_overflow;
        cause_n[`EXC_U] = i_exp_underflow & ftz_ok;
        cause_n[`EXC_I] = i_inexact | i_exp_overflow
            | (i_exp_underflow & ftz_ok);
    end

    // enables alone pick trap versus flag; unimplemented always traps
    assign trap_req = (|(cause_n[`IEEE_N-1:0] & en_q))
        | cause_n[`EXC_E];

    always_comb begin
        en_d = en_q;
        cause_d = cause_q;
        flag_d = flag_q;
        if (wr_csr) begin
            en_d = i_hwdata[`CSR_EN_LSB +: `IEEE_N];
            cause_d = i_hwdata[`CSR_CAUSE_LSB +: `CAUSE_N];
            flag_d = i_hwdata[`CSR_FLAG_LSB +: `IEEE_N];
        end
        if (i_op_valid) begin
            // a completing operation's cause wins over a same-cycle write; its flags are ORed in
            cause_d = cause_n;
            flag_d = flag_d | (cause_n[`IEEE_N-1:0] & ~en_q);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rm_q <= `RM_RESET;
            fs_q <= 1'b0;
        end else if (wr_csr) begin
            rm_q <= i_hwdata[`CSR_RM_LSB +: 2];
            fs_q <= i_hwdata[`CSR_FS_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= `EN_RESET;
            flag_q <= `FLAG_RESET;
            cause_q <= `CAUSE_RESET;
        end else begin
            en_q <= en_d;
            flag_q <= flag_d;
            cause_q <= cause_d;
        end
    end

    // ====================================================================
    // interrupt request toward the cpu
    // ====================================================================
    // the request is a level that follows cause and enable, so software
    // drops it by rewriting the cause bits in its handler
    assign irq_d = i_fp_int_en
        & ((|(cause_d[`IEEE_N-1:0] & en_d))
        | cause_d[`EXC_E]);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fp_irq <= 1'b0;
            o_exc_code <= '0;
        end else begin
            o_fp_irq <= irq_d;
            o_exc_code <= irq_d ? FLOAT_EXCEPTION_CODE : '0;
        end
    end

    // ====================================================================
    // register read data
    // ====================================================================
    always_comb begin
        csr_word = '0;
        csr_word[`CSR_RM_LSB +: 2] = rm_q;
        csr_word[`CSR_FLAG_LSB +: `IEEE_N] = flag_q;
        csr_word[`CSR_EN_LSB +: `IEEE_N] = en_q;
        csr_word[`CSR_CAUSE_LSB +: `CAUSE_N] = cause_q;
        csr_word[`CSR_FS_BIT] = fs_q;
        stat_word = '0;
        stat_word[`STAT_IRQ_BIT] = o_fp_irq;
        rd_mux = '0;
        if (i_haddr[`ADDR_W-1:0] == `CSR_ADDR) begin
            rd_mux = csr_word;
        end else if (i_haddr[`ADDR_W-1:0] == `STAT_ADDR) begin
            rd_mux = stat_word;
        end
    end

    // read data is sampled at the address phase and stands in the data
    // phase; a write in the data phase just before is not yet visible
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= '0;
        end else if (sel_rd) begin
            o_hrdata <= rd_mux;
        end
    end

    // ====================================================================
    // default results
    // ====================================================================
    function automatic logic [63:0] special(input logic dbl,
            input logic sgn, input special_type kind);
        logic [DE-1:0] de;
        logic [DM-1:0] dm;
        logic [SE-1:0] se;
        logic [SM-1:0] sm;
        de = '0;
        dm = '0;
        se = '0;
        sm = '0;
        unique case (kind)
            val_zero: begin
                de = '0;
            end
            val_inf: begin
                de = '1;
                se = '1;
            end
            val_max: begin
                de = {{(DE-1){1'b1}}, 1'b0};
                se = {{(SE-1){1'b1}}, 1'b0};
                dm = '1;
                sm = '1;
            end
            val_min: begin
                de = DE'(1);
                se = SE'(1);
            end
            val_qnan: begin
                de = '1;
                se = '1;
                dm = {1'b1, {(DM-1){1'b0}}};
                sm = {1'b1, {(SM-1){1'b0}}};
            end
            default: begin
                de = '0;
            end
        endcase
        special = dbl ? {sgn, de, dm} : {32'h0, sgn, se, sm};
    endfunction

    logic [63:0] subst;
    logic s;
    rmode_type rmode;

    assign s = i_result_sign;
    assign rmode = rmode_type'(rm_q);

    always_comb begin
        subst = i_rounded_result;
        if (cause_n[`EXC_V]) begin
            subst = special(i_op_double, 1'b0, val_qnan);
        end else if (cause_n[`EXC_Z]) begin
            subst = special(i_op_double, s, val_inf);
        end else if (cause_n[`EXC_O]) begin
            unique case (rmode)
                round_to_nearest:
                    subst = special(i_op_double, s, val_inf);
                round_toward_zero:
                    subst = special(i_op_double, s, val_max);
                round_toward_plus:
                    subst = special(i_op_double, s,
                        s ? val_max : val_inf);
                round_toward_minus:
                    subst = special(i_op_double, s,
                        s ? val_inf : val_max);
            endcase
        end else if (cause_n[`EXC_U]) begin
            unique case (rmode)
                round_to_nearest, round_toward_zero:
                    subst = special(i_op_double, s, val_zero);
                round_toward_plus:
                    subst = special(i_op_double, s,
                        s ? val_zero : val_min);
                round_toward_minus:
                    subst = special(i_op_double, s,
                        s ? val_min : val_zero);
            endcase
        end
    end

    // a trapped operation never reaches the register file
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dest_we <= 1'b0;
            o_dest_idx <= '0;
            o_dest_data <= '0;
        end else begin
            o_dest_we <= i_op_valid & ~trap_req;
            o_dest_idx <= i_dest_idx;
            o_dest_data <= subst;
        end
    end

    // ====================================================================
    // assertions
    // ====================================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic untrapped;
    assign untrapped = i_op_valid & ~trap_req;

    cause_replace_a: assert property (
        i_op_valid |=> cause_q == $past(cause_n))
        else $error("cause bits not replaced by operation");

    flag_set_a: assert property (
        i_op_valid |=> ((flag_q & $past(cause_n[`IEEE_N-1:0] & ~en_q))
            == $past(cause_n[`IEEE_N-1:0] & ~en_q)))
        else $error("flag not set for untrapped exception");

    flag_hold_a: assert property (
        (!wr_csr && i_op_valid) |=> ((flag_q ^ $past(flag_q))
            & $past(en_q)) == '0)
        else $error("flag of enabled exception changed");

    trap_irq_a: assert property (
        (i_op_valid && trap_req && i_fp_int_en && !wr_csr)
        |=> o_fp_irq && o_exc_code == FLOAT_EXCEPTION_CODE)
        else $error("trap did not raise interrupt");

    trap_no_write_a: assert property (
        (i_op_valid && trap_req) |=> !o_dest_we)
        else $error("trapped result was written");

    conv_unimpl_a: assert property (
        (i_op_valid && i_conv_overflow)
        |=> cause_q[`EXC_E] && !cause_q[`EXC_V] && !o_dest_we)
        else $error("conversion overflow not unimplemented");

    ovf_inexact_a: assert property (
        (i_op_valid && i_exp_overflow)
        |=> cause_q[`EXC_O] && cause_q[`EXC_I])
        else $error("overflow without inexact");

    ovf_nearest_a: assert property (
        (untrapped && cause_n[`EXC_O] && !cause_n[`EXC_V]
            && !cause_n[`EXC_Z] && rmode == round_to_nearest
            && !i_op_double)
        |=> o_dest_we && o_dest_data[SE+SM-1:0] == {{SE{1'b1}}, {SM{1'b0}}}
            && o_dest_data[SE+SM] == $past(s))
        else $error("overflow default not signed infinity");

    dz_inf_a: assert property (
        (untrapped && cause_n[`EXC_Z] && !cause_n[`EXC_V] && i_op_double)
        |=> o_dest_data == {$past(s), {DE{1'b1}}, {DM{1'b0}}})
        else $error("divide by zero default not infinity");

    inv_qnan_a: assert property (
        (untrapped && cause_n[`EXC_V] && i_op_double)
        |=> o_dest_data[DE+DM-1:DM] == {DE{1'b1}} && o_dest_data[DM-1])
        else $error("invalid default not quiet nan");

    irq_drop_a: assert property (
        !i_fp_int_en |=> !o_fp_irq && o_exc_code == '0)
        else $error("interrupt raised while fp interrupt disabled");

    trap_c: cover property (i_op_valid && trap_req ##1 o_fp_irq);
    untrapped_ovf_c: cover property (untrapped && cause_n[`EXC_O]);
    untrapped_unf_c: cover property (untrapped && cause_n[`EXC_U]);
    flag_write_c: cover property (wr_csr ##1 flag_q == '0);

endmodule

// >>> tb/cpu_core_model.sv
// far-side model of the integer core: fp interrupt enable and trap capture
`timescale 1ns/1ns
module cpu_core_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_fp_irq,
    input wire logic [4:0] i_exc_code,
    input wire logic i_allow,
    output logic o_fp_int_en,
    output logic [7:0] o_trap_count,
    output logic [4:0] o_last_code
);
    // ====================================================================
    // enable is a core status bit, so it only moves on the clock
    logic irq_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fp_int_en <= 1'b0;
            irq_q <= 1'b0;
            o_trap_count <= 8'h00;
            o_last_code <= 5'h00;
        end else begin
            o_fp_int_en <= i_allow;
            irq_q <= i_fp_irq;
            // a rising request is one trap; its code names the fp unit
            if (i_fp_irq && !irq_q) begin
                o_trap_count <= o_trap_count + 8'h01;
                o_last_code <= i_exc_code;
            end
        end
    end
endmodule

// >>> tb/fpu_exception_control_bench.sv
// self-checking bench for the floating-point exception control block
`timescale 1ns/1ns
module fpu_exception_control_bench;
    // ====================================================================
    // signals
    localparam logic [7:0] INX = 8'h01, INV = 8'h02, DZ = 8'h04;
    localparam logic [7:0] OVF = 8'h08, UDF = 8'h10, CONV = 8'h20;
    localparam logic [7:0] DNQ = 8'h40, UNI = 8'h80;
    logic i_clk, i_rst_n, i_hsel, i_hwrite, i_fp_int_en, allow;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, d, ew;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic o_hreadyout, o_hresp, i_op_valid, i_op_double, i_result_sign;
    logic [4:0] i_dest_idx, o_dest_idx, o_exc_code, last_code, got_code;
    logic [63:0] i_rounded_result, o_dest_data, got_data, ev;
    logic [7:0] cond, traps;
    logic o_dest_we, o_fp_irq, got_we, got_irq;
    wire logic i_hready;
    int n_mismatch, checks_done, k;
    assign i_hready = o_hreadyout;

    fpu_exception_control dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
        .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
        .i_fp_int_en(i_fp_int_en), .i_op_valid(i_op_valid),
        .i_op_double(i_op_double), .i_dest_idx(i_dest_idx),
        .i_rounded_result(i_rounded_result), .i_result_sign(i_result_sign),
        .i_inexact(cond[0]), .i_invalid(cond[1]), .i_div_zero(cond[2]),
        .i_exp_overflow(cond[3]), .i_exp_underflow(cond[4]),
        .i_conv_overflow(cond[5]), .i_denorm_qnan_src(cond[6]),
        .i_unimpl_op(cond[7]), .o_dest_we(o_dest_we),
        .o_dest_idx(o_dest_idx), .o_dest_data(o_dest_data),
        .o_fp_irq(o_fp_irq), .o_exc_code(o_exc_code)
    );
    cpu_core_model core (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fp_irq(o_fp_irq),
        .i_exc_code(o_exc_code), .i_allow(allow),
        .o_fp_int_en(i_fp_int_en), .o_trap_count(traps),
        .o_last_code(last_code)
    );

    // ====================================================================
    // helpers
    // k: 0 zero, 1 infinity, 2 largest finite, 3 smallest normal, else qnan
    function automatic logic [63:0] sv(int k, logic s, logic dd);
        case (k)
            0: return dd ? {s, 63'h0} : {32'h0, s, 31'h0};
            1: return dd ? {s, 11'h7ff, 52'h0} : {32'h0, s, 8'hff, 23'h0};
            2: return dd ? {s, 11'h7fe, {52{1'b1}}}
                         : {32'h0, s, 8'hfe, {23{1'b1}}};
            3: return dd ? {s, 11'h001, 52'h0} : {32'h0, s, 8'h01, 23'h0};
            default: return dd ? 64'h7ff8000000000000 : 64'h7fc00000;
        endcase
    endfunction
    function automatic logic [31:0] csr(logic fs, logic [5:0] ca,
                                        logic [4:0] en, logic [4:0] fl,
                                        logic [1:0] rm);
        return {7'h0, fs, 6'h0, ca, en, fl, rm};
    endfunction
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, a};
        i_hwrite <= w;
        i_hsize <= 3'h2;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, d);
        check(d, e);
    endtask
    // one completing operation; results and irq after its edge, irq read one edge later
    task automatic op(input logic dd, s, input logic [7:0] c,
                      input logic [63:0] r);
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op_double <= dd;
        i_result_sign <= s;
        i_rounded_result <= r;
        i_dest_idx <= r[4:0];
        cond <= c;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        cond <= 8'h0;
        #1;
        got_we = o_dest_we;
        got_data = o_dest_data;
        check(o_dest_idx, r[4:0]);
        @(posedge i_clk);
        #1;
        got_irq = o_fp_irq;
        got_code = o_exc_code;
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ====================================================================
    // clock, watchdog and tests
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #(20 * 20000);
        n_mismatch++;
        summarize();
    end
    initial begin
        {i_rst_n, i_hsel, i_hwrite, i_op_valid, i_op_double} = 5'h0;
        {i_result_sign, allow, i_htrans, i_hsize, cond} = 15'h0;
        {i_haddr, i_hwdata, i_dest_idx, i_rounded_result} = 133'h0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        allow <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h08, 32'hffffffff);
        rdc(8'h08, 32'h0);
        check(o_hresp, 1'b0);
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(8'h00, csr(1'b0, 6'h0, 5'h0, 5'h0, m[1:0]));
                op(m[0], s[0], OVF, 64'h5);
                k = (m == 1 || (m > 1 && (m == 2) == (s == 1))) ? 2 : 1;
                ev = sv(k, s[0], m[0]);
                check(got_we, 1'b1);
                check(got_data, ev);
                check(got_irq, 1'b0);
                ew = csr(1'b0, 6'h05, 5'h0, 5'h05, m[1:0]);
                rdc(8'h00, ew);
                wr(8'h00, csr(1'b1, 6'h0, 5'h0, 5'h0, m[1:0]));
                op(s[0], s[0], UDF, 64'h5);
                k = (m < 2) ? 0 : ((m == 2) == (s == 0)) ? 3 : 0;
                ev = sv(k, s[0], s[0]);
                check({got_we, got_data}, {1'b1, ev});
                ew = csr(1'b1, 6'h03, 5'h0, 5'h03, m[1:0]);
                rdc(8'h00, ew);
            end
        end
        op(1'b0, 1'b0, 8'h0, 64'h1234abcd);
        check({got_we, got_data}, {1'b1, 64'h1234abcd});
        rdc(8'h00, csr(1'b1, 6'h0, 5'h0, 5'h03, 2'h3));
        // software clears the sticky flags by rewriting the whole word
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'h0);
            op(1'b1, 1'b1, (i == 0) ? INX : (i == 1) ? DZ : INV,
               64'h400921fb54442d18);
            ev = (i == 0) ? 64'h400921fb54442d18
                          : sv((i == 1) ? 1 : 4, 1'b1, 1'b1);
            check({got_we, got_data}, {1'b1, ev});
            k = (i == 0) ? 0 : (i == 1) ? 3 : 4;
            ew = csr(1'b0, 6'h01 << k, 5'h0, 5'h01 << k, 2'h0);
            rdc(8'h00, ew);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h0);
            op(1'b0, 1'b0, (i == 0) ? UDF : (i == 1) ? (CONV | INV)
               : (i == 2) ? DNQ : UNI, 64'h9);
            check(got_we, 1'b0);
            check({got_irq, got_code}, {1'b1, 5'h01});
            ew = csr(1'b0, 6'h20, 5'h0, 5'h0, 2'h0);
            rdc(8'h00, ew);
        end
        wr(8'h00, csr(1'b0, 6'h0, 5'h08, 5'h0, 2'h0));
        op(1'b0, 1'b1, DZ | INX, 64'h7);
        check(got_we, 1'b0);
        check({got_irq, got_code}, {1'b1, 5'h01});
        ew = csr(1'b0, 6'h09, 5'h08, 5'h01, 2'h0);
        rdc(8'h00, ew);
        rdc(8'h04, 32'h1);
        check({traps, last_code}, {8'h05, 5'h01});
        allow <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_fp_irq, 1'b0);
        wr(8'h00, 32'h0);
        allow <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_fp_irq, 1'b0);
        summarize();
    end
endmodule
